// [pmi_dev.sv]
// Device end of the MAC interface: MII, RMII (slave/master) and RGMII.
// Assumes the line side feeds nibbles on a one-cycle line_rx_vld_i pulse.
module pmi_dev
  import pmi_pkg::*;
(
  input  wire logic              mclk_i,
  input  wire logic              rstn_i,
  input  wire pmi_pkg::pmi_mode_t mode_i,
  input  wire logic              rmii_master_strap_i,
  input  wire logic              speed100_i,
  input  wire logic              full_duplex_i,
  input  wire logic              link_up_i,
  input  wire logic [2:0]        elastic_start_threshold_i,
  input  wire logic [3:0]        line_rx_nib_i,
  input  wire logic              line_rx_vld_i,
  input  wire logic              line_rx_act_i,
  input  wire logic              line_rx_err_i,
  output logic [3:0]             line_tx_nib_o,
  output logic                   line_tx_vld_o,
  pmi_if.dev                     pin
);
  import pmi_pkg::*;

  // Four spare bits, so a nibble can land while a full buffer drains
  localparam int unsigned EB_W = EB_DEPTH + 4;

  typedef struct packed {
    pmi_mode_t  mode;
    logic       master;
    logic [1:0] ref_s;
    logic [1:0] txen_s;
    logic [3:0] txd_s0;
    logic [3:0] txd_s1;
    logic       ref_q;
    logic [3:0] div;
    logic       gclk;
    logic [7:0] hcnt;
    logic       lclk;
    logic       stretch;
    logic [EB_W-1:0] eb;
    logic [4:0] eb_cnt;
    logic       eb_run;
    logic       txhi;
    logic [3:0] tx_nib;
    logic       tx_vld;
    logic [3:0] rxd;
    logic       rx_dv;
    logic       crs_dv;
    logic       rx_er;
    logic       rx_ctl;
    logic       crs;
    logic       col;
    logic       gp3_oen;
    logic       tx_act;
    logic       started;
  } pmi_dev_st_t;

  pmi_dev_st_t s, next_s;

  function automatic logic [4:0] thr_bits(input logic [2:0] t);
    logic [2:0] c;
    c = (t < 3'(THR_MIN)) ? 3'(THR_MIN) : (t > 3'(THR_MAX)) ? 3'(THR_MAX) : t;
    return 5'(c) * 5'(THR_BITS_STEP);
  endfunction

  logic ref_rise, lclk_rise, lclk_fall;
  logic [7:0] half;

  always_comb begin
    next_s = s;
    next_s.tx_vld = 1'b0;
    // Straps taken once after reset release
    if (!s.started) begin
      next_s.started = 1'b1;
      next_s.mode    = mode_i;
      next_s.master  = rmii_master_strap_i;
    end
    next_s.ref_s  = {s.ref_s[0], pin.ref_clk};
    next_s.txen_s = {s.txen_s[0], (s.mode == PMI_RGMII) ? pin.tx_ctl : pin.tx_en};
    next_s.txd_s0 = pin.txd;
    next_s.txd_s1 = s.txd_s0;
    ref_rise = 1'b0;
    // Master mode: reference made locally, RMII slave samples pin edges
    if (s.mode == PMI_RMII && s.master) begin
      next_s.gclk    = ~s.gclk;
      next_s.gp3_oen = 1'b0;
      ref_rise       = ~s.gclk;
    end else begin
      next_s.gclk    = 1'b0;
      next_s.gp3_oen = 1'b1;
      ref_rise       = s.ref_s[0] & ~s.ref_q;
    end
    next_s.ref_q = s.ref_s[1];
    ref_rise = (s.mode == PMI_RMII && s.master) ? ~s.gclk : (s.ref_s[1] & ~s.ref_q);
    // Local MII/RGMII clock; rate fixed per speed
    half = speed100_i ? 8'(HALF_100) : 8'(HALF_10);
    lclk_rise = 1'b0;
    lclk_fall = 1'b0;
    if (s.mode != PMI_RMII) begin
      if (s.hcnt >= half - 8'h1) begin
        // Speed change applies mid-phase: a phase already past the new length ends at once
        next_s.hcnt = 8'h0;
        next_s.lclk = ~s.lclk;
        lclk_rise   = ~s.lclk;
        lclk_fall   = s.lclk;
      end else begin
        next_s.hcnt = s.hcnt + 8'h1;
      end
    end else begin
      next_s.lclk = 1'b0;
      next_s.hcnt = 8'h0;
    end
    next_s.stretch = 1'b0;
    // Elastic buffer fill from line side
    if (line_rx_vld_i && s.eb_cnt <= 5'(EB_W - 4)) begin
      // Reduced mode drains oldest first from the top, so low pair goes above
      next_s.eb     = {s.eb[EB_W-5:0], (s.mode == PMI_RMII) ?
                       {line_rx_nib_i[1:0], line_rx_nib_i[3:2]} : line_rx_nib_i};
      next_s.eb_cnt = s.eb_cnt + 5'h4;
    end
    if (!line_rx_act_i && s.eb_cnt == 5'h0) next_s.eb_run = 1'b0;
    case (s.mode)
      PMI_RMII: begin
        if (ref_rise) begin
          next_s.div = (s.div == 4'(RMII_10M_DIV - 1) || speed100_i) ? 4'h0 : s.div + 4'h1;
          if (s.div == 4'h0) begin
            if (s.txen_s[1]) begin
              next_s.tx_nib = s.txhi ? {s.txd_s1[1:0], s.tx_nib[1:0]} : {2'h0, s.txd_s1[1:0]};
              next_s.tx_vld = s.txhi;
              next_s.txhi   = ~s.txhi;
            end else begin
              next_s.txhi = 1'b0;
            end
            if (!s.eb_run && s.eb_cnt >= thr_bits(elastic_start_threshold_i)) begin
              next_s.eb_run = 1'b1;
            end
            if ((s.eb_run || next_s.eb_run) && s.eb_cnt >= 5'h2) begin
              next_s.rxd    = {2'h0, s.eb[s.eb_cnt-5'h1 -: 2]};
              next_s.eb_cnt = next_s.eb_cnt - 5'h2;
              next_s.rx_dv  = 1'b1;
            end else begin
              next_s.rxd   = 4'h0;
              next_s.rx_dv = 1'b0;
            end
            next_s.crs_dv = line_rx_act_i | (s.eb_cnt >= 5'h2);
            next_s.rx_er  = line_rx_err_i;
          end
        end
      end
      PMI_RGMII: begin
        if (lclk_rise || lclk_fall) begin
          if (lclk_rise) begin
            next_s.tx_nib = s.txd_s1;
            next_s.tx_vld = s.txen_s[1];
          end
          if (s.eb_cnt >= 5'h4) begin
            next_s.rxd    = s.eb[s.eb_cnt-5'h1 -: 4];
            next_s.rx_ctl = 1'b1;
            if (lclk_fall) next_s.eb_cnt = next_s.eb_cnt - 5'h4;
          end else begin
            next_s.rx_ctl = 1'b0;
            next_s.rxd = {full_duplex_i, speed100_i ? SPD_100 : SPD_10, link_up_i};
          end
        end
      end
      default: begin
        if (lclk_rise) begin
          next_s.tx_nib = s.txd_s1;
          next_s.tx_vld = s.txen_s[1];
          next_s.tx_act = s.txen_s[1];
          if (s.eb_cnt >= 5'h4) begin
            next_s.rxd    = s.eb[s.eb_cnt-5'h1 -: 4];
            next_s.rx_dv  = 1'b1;
            next_s.eb_cnt = next_s.eb_cnt - 5'h4;
          end else begin
            next_s.rx_dv = 1'b0;
          end
          next_s.rx_er = line_rx_err_i;
          next_s.crs   = line_rx_act_i | s.txen_s[1];
          next_s.col   = line_rx_act_i & s.txen_s[1] & ~full_duplex_i;
        end
      end
    endcase
    // Unused option pins held inactive
    if (s.mode != PMI_MII) begin
      next_s.crs = 1'b0;
      next_s.col = 1'b0;
    end
    if (s.mode != PMI_RMII) next_s.crs_dv = 1'b0;
    if (s.mode != PMI_RGMII) next_s.rx_ctl = 1'b0;
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s         <= '0;
      s.gp3_oen <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign pin.gp3_clk  = s.gclk;
  assign pin.gp3_oen  = s.gp3_oen;
  assign pin.tx_clk   = s.lclk;
  assign pin.rx_clk   = s.lclk;
  assign pin.rxd      = s.rxd;
  assign pin.rx_dv    = s.rx_dv;
  assign pin.crs_dv   = s.crs_dv;
  assign pin.rx_er    = s.rx_er;
  assign pin.rx_ctl   = s.rx_ctl;
  assign pin.crs      = s.crs;
  assign pin.col      = s.col;
  assign line_tx_nib_o = s.tx_nib;
  assign line_tx_vld_o = s.tx_vld;
endmodule

// [pmi_pkg.sv]
// Package of shared constants and types for the PHY/MAC data interface.
// Assumes a single 100 MHz system clock on both ends.
package pmi_pkg;
  localparam int unsigned CLK_MHZ       = 100;
  localparam int unsigned RMII_REF_MHZ  = 50;
  localparam int unsigned MII_MHZ_100   = 25;
  localparam int unsigned RGMII_KHZ_10  = 2500;
  localparam int unsigned RGMII_KHZ_100 = 25000;
  // Half periods in system cycles, rounded down
  localparam int unsigned HALF_REF      = CLK_MHZ / (2 * RMII_REF_MHZ);
  localparam int unsigned HALF_100      = (CLK_MHZ * 1000) / (2 * RGMII_KHZ_100);
  localparam int unsigned HALF_10       = (CLK_MHZ * 1000) / (2 * RGMII_KHZ_10);
  localparam int unsigned RMII_10M_DIV  = 10;
  localparam int unsigned THR_MIN       = 1;
  localparam int unsigned THR_MAX       = 4;
  localparam int unsigned THR_BITS_STEP = 4;
  localparam int unsigned EB_DEPTH      = 16;

  typedef enum logic [1:0] {
    PMI_MII   = 2'h0,
    PMI_RMII  = 2'h1,
    PMI_RGMII = 2'h2
  } pmi_mode_t;

  localparam logic [1:0] SPD_10   = 2'h0;
  localparam logic [1:0] SPD_100  = 2'h1;
  localparam int unsigned IB_DUP  = 3;
  localparam int unsigned IB_SPDH = 2;
  localparam int unsigned IB_SPDL = 1;
  localparam int unsigned IB_LNK  = 0;
endpackage

// [pmi_if.sv]
// Interface carrying the MAC-side pins between device end and MAC end.
// Assumes the bench joins both ends and drives nothing on it.
interface pmi_if;
  logic       ref_clk;
  logic       gp3_clk;
  logic       gp3_oen;
  logic       tx_clk;
  logic       rx_clk;
  logic [3:0] txd;
  logic       tx_en;
  logic       tx_ctl;
  logic [3:0] rxd;
  logic       rx_dv;
  logic       crs_dv;
  logic       rx_er;
  logic       rx_ctl;
  logic       crs;
  logic       col;
  modport dev (input ref_clk, txd, tx_en, tx_ctl,
               output gp3_clk, gp3_oen, tx_clk, rx_clk, rxd, rx_dv, crs_dv, rx_er, rx_ctl,
               crs, col);
  modport mac (output ref_clk, txd, tx_en, tx_ctl,
               input gp3_clk, gp3_oen, tx_clk, rx_clk, rxd, rx_dv, crs_dv, rx_er, rx_ctl,
               crs, col);
endinterface

// [pmi_mac.sv]
// MAC end of the interface: sends nibbles, receives nibbles, reads status.
// Assumes the device end runs in the same mode as mode_i.
module pmi_mac
  import pmi_pkg::*;
(
  input  wire logic               mclk_i,
  input  wire logic               rstn_i,
  input  wire pmi_pkg::pmi_mode_t mode_i,
  input  wire logic               rmii_master_i,
  input  wire logic               speed100_i,
  input  wire logic [3:0]         tx_nib_i,
  input  wire logic               tx_vld_i,
  output logic                    tx_rdy_o,
  output logic [3:0]              rx_nib_o,
  output logic                    rx_vld_o,
  output logic [3:0]              status_o,
  pmi_if.mac                      pin
);
  import pmi_pkg::*;

  typedef struct packed {
    logic       refc;
    logic [1:0] clk_s;
    logic       clk_q;
    logic [3:0] rxd_s0;
    logic [3:0] rxd_s1;
    logic [1:0] dv_s;
    logic [3:0] div;
    logic [3:0] txd;
    logic       tx_en;
    logic       half;
    logic [3:0] rx_nib;
    logic       rx_vld;
    logic       rhi;
    logic [3:0] status;
    logic       rdy;
  } pmi_mac_st_t;

  pmi_mac_st_t s, next_s;
  logic rise, fall, slot, txok;

  always_comb begin
    next_s = s;
    next_s.rx_vld = 1'b0;
    next_s.rdy    = 1'b0;
    // Slave shares our 50 MHz reference; master takes it from pin three
    next_s.refc   = ~s.refc;
    next_s.clk_s  = {s.clk_s[0], (mode_i == PMI_RMII) ?
                     (rmii_master_i ? pin.gp3_clk : s.refc) : pin.tx_clk};
    next_s.clk_q  = s.clk_s[1];
    next_s.rxd_s0 = pin.rxd;
    next_s.rxd_s1 = s.rxd_s0;
    // Separate valid used: the combined one rises before the buffer starts
    next_s.dv_s   = {s.dv_s[0], (mode_i == PMI_RMII) ? pin.rx_dv :
                     (mode_i == PMI_RGMII) ? pin.rx_ctl : pin.rx_dv};
    rise = s.clk_s[1] & ~s.clk_q;
    fall = ~s.clk_s[1] & s.clk_q;
    slot = 1'b0;
    if (rise) begin
      next_s.div = (s.div == 4'(RMII_10M_DIV - 1) || speed100_i) ? 4'h0 : s.div + 4'h1;
      slot = (mode_i != PMI_RMII) || (s.div == 4'h0);
    end
    // 10 Mbps reduced mode: change only after the device's sampling slot
    txok = fall && (mode_i != PMI_RMII || speed100_i || s.div == 4'h1);
    // Data changed only on falling edge so the device samples it stable
    if (txok && s.tx_en == 1'b0 && tx_vld_i) begin
      next_s.rdy = 1'b1;
      next_s.txd = tx_nib_i;
      next_s.tx_en = 1'b1;
    end else if (txok && s.tx_en && mode_i == PMI_RMII && !s.half) begin
      next_s.txd  = {2'h0, s.txd[3:2]};
      next_s.half = 1'b1;
    end else if (txok && s.tx_en) begin
      next_s.half  = 1'b0;
      next_s.tx_en = tx_vld_i;
      next_s.rdy   = tx_vld_i;
      next_s.txd   = tx_nib_i;
    end
    if (slot) begin
      if (s.dv_s[1]) begin
        if (mode_i == PMI_RMII) begin
          next_s.rx_nib = s.rhi ? {s.rxd_s1[1:0], s.rx_nib[1:0]} : {2'h0, s.rxd_s1[1:0]};
          next_s.rx_vld = s.rhi;
          next_s.rhi    = ~s.rhi;
        end else begin
          next_s.rx_nib = s.rxd_s1;
          next_s.rx_vld = 1'b1;
        end
      end else begin
        next_s.rhi = 1'b0;
        if (mode_i == PMI_RGMII) next_s.status = s.rxd_s1;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) s <= '0;
    else s <= next_s;
  end

  assign pin.ref_clk = s.refc;
  assign pin.txd     = s.txd;
  assign pin.tx_en   = s.tx_en;
  assign pin.tx_ctl  = s.tx_en;
  assign tx_rdy_o    = s.rdy;
  assign rx_nib_o    = s.rx_nib;
  assign rx_vld_o    = s.rx_vld;
  assign status_o    = s.status;
endmodule

// [pmi_asserts.sv]
// Checker on the joined MAC-side pins of both ends.
// Assumes mode and duplex stay steady between resets.
module pmi_asserts (
  input wire logic               mclk_i,
  input wire logic               rstn_i,
  input wire pmi_pkg::pmi_mode_t mode_i,
  input wire logic               full_duplex_i,
  input wire logic               ref_clk,
  input wire logic               gp3_clk,
  input wire logic               gp3_oen,
  input wire logic               tx_clk,
  input wire logic               rx_clk,
  input wire logic [3:0]         rxd,
  input wire logic               rx_ctl,
  input wire logic               crs_dv,
  input wire logic               crs,
  input wire logic               col
);
  import pmi_pkg::*;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  // Status is judged only long after a frame, as 10 Mbps lags
  typedef struct packed {
    logic [6:0] idle;
  } pmi_chk_t;
  pmi_chk_t st;
  pmi_chk_t next_st;
  always_comb begin
    next_st = st;
    if (rx_ctl) next_st.idle = 7'h0;
    else if (st.idle != 7'h7f) next_st.idle = st.idle + 7'h1;
  end
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) st <= '0;
    else st <= next_st;
  end
  sequence s_rx_high; rx_clk [*2]; endsequence
  sequence s_tx_low; !tx_clk [*2]; endsequence
  a_col_with_crs: assert property (col |-> crs)
    else $error("collision without carrier");
  a_col_half_mii: assert property (col |-> !full_duplex_i && mode_i == PMI_MII)
    else $error("collision outside half duplex");
  a_gp3_master_only: assert property (!gp3_oen |-> mode_i == PMI_RMII)
    else $error("pin three driven outside reduced mode");
  a_gp3_clk_steady: assert property ($past(gp3_clk) != $past(gp3_clk, 2) && !gp3_oen
    |-> gp3_clk != $past(gp3_clk))
    else $error("pin three clock stalled");
  a_ref_clk_steady: assert property ($past(ref_clk) != $past(ref_clk, 2)
    |-> ref_clk != $past(ref_clk))
    else $error("reference clock stalled");
  a_crs_dv_idle: assert property (mode_i != PMI_RMII |-> !crs_dv)
    else $error("combined valid active outside reduced mode");
  a_rx_ctl_idle: assert property (mode_i != PMI_RGMII |-> !rx_ctl)
    else $error("receive control active outside rgmii");
  a_rmii_no_clks: assert property (mode_i == PMI_RMII |-> !tx_clk && !rx_clk)
    else $error("nibble clocks run in reduced mode");
  a_rx_clk_high: assert property ($rose(rx_clk) |-> s_rx_high)
    else $error("receive clock high phase too short");
  a_tx_clk_low: assert property ($fell(tx_clk) |-> s_tx_low)
    else $error("transmit clock low phase too short");
  a_status_legal: assert property (mode_i == PMI_RGMII && st.idle == 7'h7f
    |-> !rxd[IB_SPDH] && rxd[IB_DUP] == full_duplex_i)
    else $error("bad in-band status");
endmodule

// [testbench.sv]
// Bench joining both ends: random nibbles both ways in every mode.
// Assumes the hand-over timing; a fixed seed keeps runs repeatable.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import pmi_pkg::*;
  logic       mclk_i = 1'b0;
  logic       rstn_i = 1'b0;
  pmi_mode_t  mode = PMI_MII;
  logic       master = 1'b0, spd = 1'b1, fd = 1'b0, link = 1'b0;
  logic [2:0] thr = 3'h1;
  logic [3:0] lrx_nib = 4'h0, tx_nib = 4'h0;
  logic       lrx_vld = 1'b0, lrx_act = 1'b0, lrx_err = 1'b0, tx_vld = 1'b0;
  logic [3:0] ltx_nib, rx_nib, status;
  logic       ltx_vld, tx_rdy, rx_vld, saw_col, saw_crs;
  logic [3:0] q_tx[$], q_rx[$];
  int         n_mismatch = 0, checks = 0;
  pmi_if pmi_if_inst();
  pmi_dev pmi_dev_inst (.mclk_i(mclk_i), .rstn_i(rstn_i), .mode_i(mode),
    .rmii_master_strap_i(master), .speed100_i(spd), .full_duplex_i(fd), .link_up_i(link),
    .elastic_start_threshold_i(thr), .line_rx_nib_i(lrx_nib), .line_rx_vld_i(lrx_vld),
    .line_rx_act_i(lrx_act), .line_rx_err_i(lrx_err), .line_tx_nib_o(ltx_nib),
    .line_tx_vld_o(ltx_vld), .pin(pmi_if_inst.dev));
  pmi_mac pmi_mac_inst (.mclk_i(mclk_i), .rstn_i(rstn_i), .mode_i(mode), .rmii_master_i(master),
    .speed100_i(spd), .tx_nib_i(tx_nib), .tx_vld_i(tx_vld), .tx_rdy_o(tx_rdy),
    .rx_nib_o(rx_nib), .rx_vld_o(rx_vld), .status_o(status), .pin(pmi_if_inst.mac));
  pmi_asserts pmi_asserts_inst (.mclk_i(mclk_i), .rstn_i(rstn_i), .mode_i(mode),
    .full_duplex_i(fd), .ref_clk(pmi_if_inst.ref_clk), .gp3_clk(pmi_if_inst.gp3_clk),
    .gp3_oen(pmi_if_inst.gp3_oen), .tx_clk(pmi_if_inst.tx_clk), .rx_clk(pmi_if_inst.rx_clk),
    .rxd(pmi_if_inst.rxd), .rx_ctl(pmi_if_inst.rx_ctl), .crs_dv(pmi_if_inst.crs_dv),
    .crs(pmi_if_inst.crs), .col(pmi_if_inst.col));
  always #5 mclk_i = ~mclk_i;
  task automatic results();
    $display("mismatches %0d, checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic fail(input string msg);
    n_mismatch++;
    $display("unexpected at %0t: %s", $time, msg);
  endtask
  task automatic cmp(input logic [3:0] got, input logic [3:0] exp, input string msg);
    checks++;
    if (got !== exp) fail(msg);
  endtask
  function automatic logic [3:0] exp_status(input logic f, input logic s, input logic l);
    return {f, s ? SPD_100 : SPD_10, l};
  endfunction
  // Nibbles must arrive whole and in order at the far end
  always @(negedge mclk_i) begin
    if (pmi_if_inst.col === 1'b1) saw_col = 1'b1;
    if (pmi_if_inst.crs === 1'b1) saw_crs = 1'b1;
    if (ltx_vld === 1'b1) begin
      if (q_tx.size() == 0) fail("line nibble with none sent");
      else cmp(ltx_nib, q_tx.pop_front(), "line nibble");
    end
    if (rx_vld === 1'b1) begin
      if (q_rx.size() == 0) fail("mac nibble with none sent");
      else cmp(rx_nib, q_rx.pop_front(), "mac nibble");
    end
  end
  // Holds the request up between nibbles, so no double assignment at one edge
  task automatic send_tx(input logic [3:0] d);
    int k;
    k = 0;
    q_tx.push_back(d);
    tx_nib = d;
    tx_vld = 1'b1;
    do begin
      @(negedge mclk_i);
      k++;
    end while (tx_rdy !== 1'b1 && k < 500);
    if (k >= 500) begin
      fail("transmit handshake hung");
      results();
    end
  endtask
  task automatic run(input pmi_mode_t m, input logic ms, input logic s, input logic f);
    int per;
    int n;
    logic [3:0] v;
    @(negedge mclk_i);
    rstn_i = 1'b0;
    mode = m;
    master = ms;
    spd = s;
    fd = f;
    link = 1'($urandom);
    thr = 3'($urandom_range(THR_MAX, THR_MIN));
    per = s ? 2 * HALF_100 : 2 * HALF_10;
    repeat (10) @(negedge mclk_i);
    rstn_i = 1'b1;
    repeat (4) @(negedge mclk_i);
    saw_col = 1'b0;
    saw_crs = 1'b0;
    fork
      begin
        for (int i = 0; i < 8; i++) send_tx(i == 0 ? 4'hf : 4'($urandom));
        tx_vld = 1'b0;
      end
      begin
        lrx_act = 1'b1;
        for (int i = 0; i < 8; i++) begin
          v = i == 7 ? 4'h0 : 4'($urandom);
          q_rx.push_back(v);
          lrx_nib = v;
          lrx_vld = 1'b1;
          @(negedge mclk_i);
          lrx_vld = 1'b0;
          repeat (per - 1) @(negedge mclk_i);
        end
        lrx_act = 1'b0;
      end
    join
    n = 0;
    while ((q_tx.size() != 0 || q_rx.size() != 0) && n < 1000) begin
      @(negedge mclk_i);
      n++;
    end
    if (n >= 1000) begin
      fail("nibbles lost");
      results();
    end
    repeat (4 * per) @(negedge mclk_i);
    cmp({3'h0, saw_col}, {3'h0, m == PMI_MII && !f}, "collision");
    cmp({3'h0, saw_crs}, {3'h0, m == PMI_MII}, "carrier");
    if (m == PMI_RGMII) cmp(status, exp_status(f, s, link), "in-band status");
  endtask
  initial begin
    void'($urandom(50100));
    run(PMI_MII, 1'b0, 1'b1, 1'b0);
    run(PMI_MII, 1'b0, 1'b0, 1'b1);
    run(PMI_RMII, 1'b0, 1'b1, 1'b1);
    run(PMI_RMII, 1'b1, 1'b0, 1'b0);
    run(PMI_RMII, 1'b1, 1'b1, 1'b1);
    run(PMI_RGMII, 1'b0, 1'b1, 1'b1);
    run(PMI_RGMII, 1'b0, 1'b0, 1'b0);
    results();
  end
endmodule
